// File: rtl/standby_wakeup_defs.svh
// constants for the standby and wake-up controller
// assumes: included by the package and by the controller, guarded against reuse
`ifndef STANDBY_WAKEUP_DEFS_SVH
`define STANDBY_WAKEUP_DEFS_SVH

// standby mode select codes
`define STBY_SEL_W      2
`define STBY_STOP       2'h1
`define STBY_SLEEP      2'h2
`define STBY_IDLE       2'h3

// warm-up time select codes
`define WUP_SEL_W       2
`define WUP_SEL_2P8     2'h1
`define WUP_SEL_2P14    2'h2
`define WUP_SEL_2P16    2'h3

// widths and reset values
`define WARM_CNT_W      17
`define WARM_CNT_ZERO   17'h0_0000
`define LEVEL_W         3

`endif

// File: rtl/standby_wakeup_pkg.sv
// types of the standby and wake-up controller
// assumes: the constants header sits beside this file
package standby_wakeup_pkg;
`include "standby_wakeup_defs.svh"

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_IDLE,
        ST_SLEEP,
        ST_STOP,
        ST_WARMUP
    } pm_state_t;

    typedef struct packed {
        pm_state_t               st;
        logic                    doze;
        logic                    slow;
        logic                    rs_main;
        logic                    rs_low;
        logic                    rs_slow;
        logic                    drive;
        logic [`WARM_CNT_W-1:0]  cnt;
        logic [`WARM_CNT_W-1:0]  cnt_last;
        logic                    isr;
        logic                    wake_pulse;
        logic                    cpu_run;
        logic                    sysclk_run;
        logic                    main_osc_run;
        logic                    low_osc_run;
        logic                    dma_run;
        logic                    pins_drive;
        logic                    pins_in_en;
        logic                    ale_low;
        logic                    osc_out_high;
    } ctl_t;

endpackage

// File: rtl/standby_wakeup_control.sv
// standby entry, wake-up filtering, warm-up timing and stop-mode pin control
// assumes: one 20 MHz clock that keeps running for this block; i_rst_n is the
// reset pin; the oscillator cycle is counted as one clock cycle
`timescale 1ns/1ps
`include "standby_wakeup_defs.svh"

module standby_wakeup_control
    import standby_wakeup_pkg::*;
#(
    parameter int N_EXT_WAKE    = 5,
    parameter int N_EXT_OTHER   = 6,
    parameter int N_PERIPH      = 24,
    parameter int WARM_CYC_SEL1 = 256,
    parameter int WARM_CYC_SEL2 = 16384,
    parameter int WARM_CYC_SEL3 = 65536,
    parameter int WARM_CYC_RST  = 16384
) (
    // clock and reset
    input  wire logic                              i_clk_sys,
    input  wire logic                              i_rst_n,
    // standby entry and configuration
    input  wire logic                              i_standby_req,
    input  wire logic                              i_doze_req,
    input  wire logic [`STBY_SEL_W-1:0]            i_standby_mode_sel,
    input  wire logic [`WUP_SEL_W-1:0]             i_warmup_time_select,
    input  wire logic                              i_stop_pin_drive_enable,
    input  wire logic                              i_resume_main_osc_enable,
    input  wire logic                              i_resume_low_osc_enable,
    input  wire logic                              i_resume_sysclk_select,
    input  wire logic [`LEVEL_W-1:0]               i_mask_level,
    // wake sources
    input  wire logic                              i_nmi,
    input  wire logic                              i_watchdog_irq,
    input  wire logic [N_EXT_WAKE-1:0]             i_ext_wake_irqs,
    input  wire logic                              i_clock_calendar_irq,
    input  wire logic [N_EXT_OTHER-1:0]            i_ext_other_irqs,
    input  wire logic [N_PERIPH-1:0]               i_periph_irqs,
    input  wire logic                              i_dma_done_irq,
    // per-source enable and level from the irq_controller
    input  wire logic [N_EXT_WAKE+N_EXT_OTHER+N_PERIPH+1:0] i_src_enable,
    input  wire logic [(N_EXT_WAKE+N_EXT_OTHER+N_PERIPH+2)*`LEVEL_W-1:0] i_src_level,
    // clock control
    output logic                                   o_cpu_run,
    output logic                                   o_sysclk_run,
    output logic                                   o_main_osc_run,
    output logic                                   o_low_osc_run,
    output logic                                   o_dma_run,
    output logic                                   o_slow_mode,
    // wake outcome
    output logic                                   o_resume_isr,
    output logic                                   o_wake_pulse,
    // pin control
    output logic                                   o_pins_drive,
    output logic                                   o_pins_in_en,
    output logic                                   o_ale_low,
    output logic                                   o_osc_out_high
);

    localparam int NSRC = N_EXT_WAKE + N_EXT_OTHER + N_PERIPH + 2;
    localparam int CW   = `WARM_CNT_W;

    ctl_t cur;
    ctl_t next_cur;

    logic [NSRC-1:0] src_req;
    logic [NSRC-1:0] src_ok;
    logic [NSRC-1:0] src_unmasked;
    logic            nmi_wake;
    logic            wake_any;
    logic            wake_isr;

    function automatic logic [CW-1:0] warm_terminal(input logic [`WUP_SEL_W-1:0] sel);
        logic [CW-1:0] t;
        t = CW'(WARM_CYC_SEL1 - 1);
        case (sel)
            `WUP_SEL_2P8:  t = CW'(WARM_CYC_SEL1 - 1);
            `WUP_SEL_2P14: t = CW'(WARM_CYC_SEL2 - 1);
            `WUP_SEL_2P16: t = CW'(WARM_CYC_SEL3 - 1);
            default:       t = CW'(WARM_CYC_SEL1 - 1);
        endcase
        return t;
    endfunction

    // ------------------------------------------------------------
    // wake source filtering
    // ------------------------------------------------------------
    assign src_req = {i_dma_done_irq, i_periph_irqs, i_ext_other_irqs,
                      i_clock_calendar_irq, i_ext_wake_irqs};

    // cpu-level interrupt disable is not an input: a source left enabled in
    // the controller still wakes idle (dma only in doze); sleep and stop admit only their wake sources
    for (genvar g = 0; g < NSRC; g++) begin : g_src
        localparam bit IS_WAKE = (g < N_EXT_WAKE);
        localparam bit IS_RTC  = (g == N_EXT_WAKE);
        localparam bit IS_DMA  = (g == NSRC - 1);
        logic permit;
        always_comb begin
            case (cur.st)
                ST_IDLE:  permit = IS_DMA ? cur.doze : 1'b1;
                ST_SLEEP: permit = IS_WAKE | IS_RTC;
                ST_STOP:  permit = IS_WAKE;
                default:  permit = 1'b0;
            endcase
        end
        assign src_ok[g]       = src_req[g] & i_src_enable[g] & permit;
        assign src_unmasked[g] = i_src_level[g*`LEVEL_W +: `LEVEL_W] > i_mask_level;
    end

    // watchdog behaves as non-maskable but cannot reach stop
    assign nmi_wake = i_nmi | (i_watchdog_irq & (cur.st == ST_IDLE | cur.st == ST_SLEEP));
    assign wake_any = nmi_wake | (|src_ok);
    assign wake_isr = nmi_wake | (|(src_ok & src_unmasked));

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic run;
        run = 1'b0;
        next_cur = cur;
        next_cur.wake_pulse = 1'b0;
        case (cur.st)
            ST_NORMAL: begin
                if (i_standby_req | i_doze_req) begin
                    // resume bits are latched at entry so late writes cannot leak in
                    next_cur.rs_main  = i_resume_main_osc_enable;
                    next_cur.rs_low   = i_resume_low_osc_enable;
                    next_cur.rs_slow  = i_resume_sysclk_select;
                    next_cur.drive    = i_stop_pin_drive_enable;
                    next_cur.cnt_last = warm_terminal(i_warmup_time_select);
                    next_cur.cnt      = `WARM_CNT_ZERO;
                    next_cur.doze     = i_doze_req;
                    if (i_doze_req) begin
                        next_cur.st = ST_IDLE;
                    end else begin
                        case (i_standby_mode_sel)
                            `STBY_STOP:  next_cur.st = ST_STOP;
                            `STBY_SLEEP: next_cur.st = ST_SLEEP;
                            default:     next_cur.st = ST_IDLE;
                        endcase
                    end
                end
            end
            ST_IDLE: begin
                if (wake_any) begin
                    next_cur.st         = ST_NORMAL;
                    next_cur.isr        = wake_isr;
                    next_cur.wake_pulse = 1'b1;
                end
            end
            ST_SLEEP, ST_STOP: begin
                if (wake_any) begin
                    next_cur.st  = ST_WARMUP;
                    next_cur.isr = wake_isr;
                end
            end
            ST_WARMUP: begin
                if (cur.cnt == cur.cnt_last) begin
                    next_cur.st         = ST_NORMAL;
                    next_cur.slow       = cur.rs_slow;
                    next_cur.wake_pulse = 1'b1;
                end else begin
                    next_cur.cnt = cur.cnt + CW'(1);
                end
            end
            default: next_cur.st = ST_NORMAL;
        endcase

        // clock and pin outputs follow the state being entered
        run = (next_cur.st == ST_NORMAL);
        next_cur.cpu_run      = run;
        next_cur.sysclk_run   = run;
        next_cur.main_osc_run = ((run & (next_cur.rs_main | ~next_cur.slow))
                                | next_cur.st == ST_IDLE
                                | next_cur.st == ST_WARMUP);
        next_cur.low_osc_run  = (run & next_cur.rs_low) | next_cur.st == ST_SLEEP;
        next_cur.dma_run      = run | (next_cur.st == ST_IDLE & next_cur.doze);
        next_cur.pins_drive   = (next_cur.st != ST_STOP) | next_cur.drive;
        next_cur.pins_in_en   = (next_cur.st != ST_STOP) | next_cur.drive;
        next_cur.ale_low      = (next_cur.st == ST_STOP);
        next_cur.osc_out_high = (next_cur.st == ST_STOP);
    end

    // reset lands in warm-up so the oscillator settles before the cpu runs
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur              <= '0;
            cur.st           <= ST_WARMUP;
            cur.cnt_last     <= CW'(WARM_CYC_RST - 1);
            cur.rs_main      <= 1'b1;
            cur.pins_drive   <= 1'b1;
            cur.pins_in_en   <= 1'b1;
            cur.main_osc_run <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_cpu_run      = cur.cpu_run;
    assign o_sysclk_run   = cur.sysclk_run;
    assign o_main_osc_run = cur.main_osc_run;
    assign o_low_osc_run  = cur.low_osc_run;
    assign o_dma_run      = cur.dma_run;
    assign o_slow_mode    = cur.slow;
    assign o_resume_isr   = cur.isr;
    assign o_wake_pulse   = cur.wake_pulse;
    assign o_pins_drive   = cur.pins_drive;
    assign o_pins_in_en   = cur.pins_in_en;
    assign o_ale_low      = cur.ale_low;
    assign o_osc_out_high = cur.osc_out_high;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_stop_entry;
        cur.st == ST_NORMAL && i_standby_req && !i_doze_req
            && i_standby_mode_sel == `STBY_STOP;
    endsequence

    sequence s_stop_wake;
        cur.st == ST_STOP && (i_nmi || |(i_ext_wake_irqs & i_src_enable[N_EXT_WAKE-1:0]));
    endsequence

    property p_stop_clocks_off;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        cur.st == ST_STOP |-> !o_sysclk_run && !o_main_osc_run && !o_cpu_run;
    endproperty
    a_stop_clocks_off: assert property (p_stop_clocks_off)
        else $error("clock running in stop");

    property p_stop_wake_warmup;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        s_stop_wake |=> cur.st == ST_WARMUP && !o_sysclk_run && o_main_osc_run;
    endproperty
    a_stop_wake_warmup: assert property (p_stop_wake_warmup)
        else $error("stop wake did not start warm-up");

    property p_stop_ignores_other;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        cur.st == ST_STOP && !i_nmi && (src_req & i_src_enable) != '0
            && (src_req[N_EXT_WAKE-1:0] & i_src_enable[N_EXT_WAKE-1:0]) == '0
            |=> cur.st == ST_STOP;
    endproperty
    a_stop_ignores_other: assert property (p_stop_ignores_other)
        else $error("stop ended by a non-wake source");

    property p_warmup_length;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        s_stop_wake ##1 (cur.st == ST_WARMUP && cur.cnt_last == CW'(WARM_CYC_SEL1 - 1))
            |-> !o_sysclk_run [*8];
    endproperty
    a_warmup_length: assert property (p_warmup_length)
        else $error("system clock back before warm-up");

    property p_warmup_done;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        cur.st == ST_WARMUP && cur.cnt == cur.cnt_last
            |=> o_sysclk_run && o_wake_pulse && o_slow_mode == $past(cur.rs_slow);
    endproperty
    a_warmup_done: assert property (p_warmup_done)
        else $error("warm-up completion not released");

    property p_select_terminal;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        s_stop_entry and (i_warmup_time_select == `WUP_SEL_2P14)
            |=> cur.cnt_last == CW'(WARM_CYC_SEL2 - 1);
    endproperty
    a_select_terminal: assert property (p_select_terminal)
        else $error("wrong warm-up count");

    property p_halt_ignores_dma;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        cur.st == ST_IDLE && !cur.doze && !nmi_wake
            && (src_req & i_src_enable) == {1'b1, {(NSRC-1){1'b0}}}
            |=> cur.st == ST_IDLE;
    endproperty
    a_halt_ignores_dma: assert property (p_halt_ignores_dma)
        else $error("dma woke halt idle");

    property p_nmi_to_isr;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        cur.st == ST_IDLE && i_nmi |=> o_resume_isr && o_cpu_run && o_wake_pulse;
    endproperty
    a_nmi_to_isr: assert property (p_nmi_to_isr)
        else $error("nmi wake missed handler");

    property p_masked_resume;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        cur.st == ST_IDLE && !nmi_wake && src_ok != '0 && (src_ok & src_unmasked) == '0
            |=> !o_resume_isr && o_cpu_run;
    endproperty
    a_masked_resume: assert property (p_masked_resume)
        else $error("masked wake took handler");

    property p_stop_pins;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        s_stop_entry |=> o_pins_drive == $past(i_stop_pin_drive_enable)
            && o_ale_low && o_osc_out_high;
    endproperty
    a_stop_pins: assert property (p_stop_pins)
        else $error("stop pin states wrong");

endmodule // standby_wakeup_control

// File: dv/wake_source_model.sv
// wake source model: nmi, watchdog and interrupt request lines of the system
// assumes: shares the controller clock; all requests are level, active high
`timescale 1ns/1ps

module wake_source_model (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // commands from the bench
    input  wire logic        i_fire,
    input  wire logic        i_drop,
    input  wire logic [2:0]  i_group,
    input  wire logic [4:0]  i_bit,
    // processing has begun once the cpu runs
    input  wire logic        i_cpu_run,
    // request lines
    output logic             o_nmi,
    output logic             o_watchdog_irq,
    output logic [4:0]       o_ext_wake_irqs,
    output logic             o_clock_calendar_irq,
    output logic [5:0]       o_ext_other_irqs,
    output logic [23:0]      o_periph_irqs,
    output logic             o_dma_done_irq
);
    logic       active;
    logic [2:0] group;
    logic [4:0] bitn;

    // a level request is held until processing begins; dropping it sooner loses it
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            active <= 1'b0;
        end else if (i_drop || i_cpu_run) begin
            active <= 1'b0;
        end else if (i_fire) begin
            active <= 1'b1;
            group  <= i_group;
            bitn   <= i_bit;
        end
    end

    always_comb begin
        o_nmi                = active && group == 3'h0;
        o_watchdog_irq       = active && group == 3'h1;
        o_ext_wake_irqs      = (active && group == 3'h2) ? 5'h01 << bitn : 5'h00;
        o_clock_calendar_irq = active && group == 3'h3;
        o_ext_other_irqs     = (active && group == 3'h4) ? 6'h01 << bitn : 6'h00;
        o_periph_irqs        = (active && group == 3'h5) ? 24'h00_0001 << bitn : 24'h00_0000;
        o_dma_done_irq       = active && group == 3'h6;
    end
endmodule // wake_source_model

// File: dv/standby_wakeup_control_test.sv
// self-checking bench for the standby and wake-up controller
// assumes: warm-up counts shortened by parameter; wake requests come from the model
`timescale 1ns/1ps
`include "standby_wakeup_defs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
$display("FAIL %s expected %0h seen %0h", nm, e, g); end end

module standby_wakeup_control_test;
    import standby_wakeup_pkg::*;
    // shortest select kept at 8 so the controller's 8-cycle warm-up check still holds
    localparam int W1 = 8;
    localparam int W2 = 16;
    localparam int W3 = 32;
    localparam int WR = 8;
    localparam logic [1:0] MI = `STBY_IDLE;
    localparam logic [1:0] MS = `STBY_SLEEP;
    localparam logic [1:0] MT = `STBY_STOP;
    typedef struct packed {
        logic [1:0] msel;
        logic       doze;
        logic [2:0] grp;
        logic [4:0] bitn;
        logic       en;
        logic [2:0] lvl;
        logic [2:0] mask;
        logic [1:0] wsel;
        logic       drv;
        logic       slow;
        logic       wake;
        logic       isr;
    } row_t;
    // group: 0 nmi, 1 watchdog, 2 ext wake, 3 calendar, 4 ext other, 5 periph, 6 dma
    row_t rows [21] = '{
        '{MI, 0, 2, 0, 1, 5, 3, 1, 0, 0, 1, 1},
        '{MI, 0, 2, 4, 1, 2, 3, 1, 0, 0, 1, 0},
        '{MI, 0, 2, 1, 1, 3, 3, 1, 0, 0, 1, 0},
        '{0, 0, 5, 23, 1, 6, 0, 1, 0, 0, 1, 1},
        '{MI, 0, 4, 5, 1, 1, 4, 1, 0, 0, 1, 0},
        '{MI, 0, 6, 0, 1, 7, 0, 1, 0, 0, 0, 0},
        '{MT, 1, 6, 0, 1, 7, 0, 1, 0, 0, 1, 1},
        '{MI, 0, 5, 0, 0, 7, 0, 1, 0, 0, 0, 0},
        '{MI, 0, 1, 0, 1, 0, 7, 1, 0, 0, 1, 1},
        '{MS, 0, 3, 0, 1, 4, 1, 2, 0, 1, 1, 1},
        '{MS, 0, 5, 3, 1, 7, 0, 1, 0, 0, 0, 0},
        '{MS, 0, 4, 0, 1, 7, 0, 1, 0, 0, 0, 0},
        '{MS, 0, 1, 0, 1, 0, 0, 1, 0, 0, 1, 1},
        '{MT, 0, 2, 2, 1, 6, 2, 1, 0, 0, 1, 1},
        '{MT, 0, 2, 3, 1, 1, 5, 2, 1, 1, 1, 0},
        '{MT, 0, 2, 0, 1, 6, 0, 3, 0, 0, 1, 1},
        '{MT, 0, 2, 1, 1, 6, 0, 0, 1, 0, 1, 1},
        '{MT, 0, 3, 0, 1, 7, 0, 1, 0, 0, 0, 0},
        '{MT, 0, 1, 0, 1, 0, 0, 1, 0, 0, 0, 0},
        '{MT, 0, 0, 0, 1, 0, 7, 1, 1, 0, 1, 1},
        '{MT, 0, 5, 5, 1, 7, 0, 1, 0, 0, 0, 0}
    };
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         stby = 1'b0;
    logic         doze = 1'b0;
    logic [1:0]   msel = 2'h0;
    logic [1:0]   wsel = 2'h1;
    logic         drv = 1'b0;
    logic         slow = 1'b0;
    logic [2:0]   mask = 3'h0;
    logic [36:0]  en = '1;
    logic [110:0] lvl = '0;
    logic         fire = 1'b0;
    logic         drop = 1'b0;
    logic [2:0]   grp = 3'h0;
    logic [4:0]   bitn = 5'h0;
    logic         nmi, wdt, cal, dma;
    logic [4:0]   ew;
    logic [5:0]   eo;
    logic [23:0]  per;
    logic         cpu_run, sysclk_run, main_osc, dma_run, slow_mode, isr, wpulse;
    logic         pdrive, pin_en, ale_low, osc_high, low_osc;
    int           failures = 0;
    int           comparisons = 0;
    int           n;

    always #25 clk = ~clk;

    wake_source_model src (.i_clk_sys(clk), .i_rst_n(rst_n), .i_fire(fire), .i_drop(drop),
        .i_group(grp), .i_bit(bitn), .i_cpu_run(cpu_run), .o_nmi(nmi), .o_watchdog_irq(wdt),
        .o_ext_wake_irqs(ew), .o_clock_calendar_irq(cal), .o_ext_other_irqs(eo),
        .o_periph_irqs(per), .o_dma_done_irq(dma));

    standby_wakeup_control #(.WARM_CYC_SEL1(W1), .WARM_CYC_SEL2(W2), .WARM_CYC_SEL3(W3),
        .WARM_CYC_RST(WR)) dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_standby_req(stby),
        .i_doze_req(doze), .i_standby_mode_sel(msel), .i_warmup_time_select(wsel),
        .i_stop_pin_drive_enable(drv), .i_resume_main_osc_enable(1'b1),
        .i_resume_low_osc_enable(slow), .i_resume_sysclk_select(slow), .i_mask_level(mask),
        .i_nmi(nmi), .i_watchdog_irq(wdt), .i_ext_wake_irqs(ew), .i_clock_calendar_irq(cal),
        .i_ext_other_irqs(eo), .i_periph_irqs(per), .i_dma_done_irq(dma), .i_src_enable(en),
        .i_src_level(lvl), .o_cpu_run(cpu_run), .o_sysclk_run(sysclk_run),
        .o_main_osc_run(main_osc), .o_low_osc_run(low_osc), .o_dma_run(dma_run),
        .o_slow_mode(slow_mode), .o_resume_isr(isr), .o_wake_pulse(wpulse),
        .o_pins_drive(pdrive), .o_pins_in_en(pin_en), .o_ale_low(ale_low),
        .o_osc_out_high(osc_high));

    // one edge for the controller to take the wake, then the warm-up; the model's latch edge falls before the count
    function automatic int lat(input row_t r);
        if (r.doze || !(r.msel inside {MT, MS})) return 1;
        return (r.wsel == 2'h3 ? W3 : r.wsel == 2'h2 ? W2 : W1) + 1;
    endfunction

    task automatic summarize();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_run();
        n = 0;
        while (cpu_run !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic enter(input logic [1:0] m, input logic d);
        @(negedge clk);
        msel = m;
        stby = !d;
        doze = d;
        @(negedge clk);
        stby = 1'b0;
        doze = 1'b0;
        `CHK("cpu_run at entry", 1'b0, cpu_run)
        `CHK("sysclk_run at entry", 1'b0, sysclk_run)
        `CHK("dma_run at entry", d, dma_run)
    endtask

    task automatic raise(input logic [2:0] g, input logic [4:0] b);
        grp = g;
        bitn = b;
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
        wait_run();
    endtask

    task automatic do_reset(input int hold);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (hold) @(negedge clk);
        `CHK("cpu_run in reset", 1'b0, cpu_run)
        `CHK("main_osc_run in reset", 1'b1, main_osc)
        `CHK("pins_drive in reset", 1'b1, pdrive)
        `CHK("ale_low in reset", 1'b0, ale_low)
        rst_n = 1'b1;
        wait_run();
        `CHK("reset warm-up", WR, n)
        `CHK("resume_isr after reset", 1'b0, isr)
    endtask

    task automatic run_row(input row_t r);
        wsel = r.wsel;
        drv = r.drv;
        slow = r.slow;
        mask = r.mask;
        lvl = {37{r.lvl}};
        en = r.en ? '1 : ~(37'h0_0000_0001 << (12 + r.bitn));
        enter(r.msel, r.doze);
        if (r.msel == MT && !r.doze) begin
            `CHK("main_osc_run in stop", 1'b0, main_osc)
            `CHK("ale_low in stop", 1'b1, ale_low)
            `CHK("osc_out_high in stop", 1'b1, osc_high)
            `CHK("pins_drive in stop", r.drv, pdrive)
            `CHK("pins_in_en in stop", r.drv, pin_en)
        end
        if (r.msel == MS && !r.doze) `CHK("low_osc_run in sleep", 1'b1, low_osc)
        raise(r.grp, r.bitn);
        if (r.wake) begin
            `CHK("wake latency", lat(r), n)
            `CHK("resume_isr", r.isr, isr)
            `CHK("wake_pulse", 1'b1, wpulse)
            `CHK("main_osc_run after wake", 1'b1, main_osc)
            `CHK("ale_low after wake", 1'b0, ale_low)
            `CHK("low_osc_run after wake", r.slow, low_osc)
            if (lat(r) > 1) `CHK("slow_mode", r.slow, slow_mode)
            @(negedge clk);
            `CHK("wake_pulse width", 1'b0, wpulse)
        end else begin
            `CHK("no wake", 1'b0, cpu_run)
            drop = 1'b1;
            @(negedge clk);
            drop = 1'b0;
            raise(3'h0, 5'h0);
            `CHK("nmi wake", 1'b1, cpu_run)
        end
    endtask

    initial begin
        do_reset(8);
        foreach (rows[i]) run_row(rows[i]);
        // a stop request while idling is ignored, so a peripheral still wakes at once
        enter(MI, 1'b0);
        @(negedge clk);
        stby = 1'b1;
        msel = MT;
        @(negedge clk);
        stby = 1'b0;
        raise(3'h5, 5'h7);
        `CHK("request in standby ignored", 1, n)
        stby = 1'b1;
        msel = MI;
        @(negedge clk);
        stby = 1'b0;
        `CHK("back-to-back entry", 1'b0, cpu_run)
        raise(3'h0, 5'h0);
        enter(MT, 1'b0);
        // reset wake from stop held for the long flash settling span
        do_reset(10000);
        summarize();
    end

    initial begin
        repeat (16000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule // standby_wakeup_control_test
